// ==== rtl/bdl_pkg.sv ====
package bdl_pkg;

	// ********************************
	// Bit and sync timing, debug clock cycles
	// ********************************
	localparam logic [4:0] BIT_CYC = 5'h10;
	localparam logic [4:0] SAMPLE_CYC = 5'h0A;
	localparam logic [4:0] SPEEDUP_CYC = 5'h07;
	localparam logic [4:0] SPEEDUP_END = 5'h08;
	localparam logic [4:0] TX0_LOW_CYC = 5'h0D;
	localparam logic [4:0] TX0_END = 5'h0E;
	localparam logic [9:0] TIMEOUT_CYC = 10'h200;
	localparam logic [6:0] SYNC_DETECT_CYC = 7'h40;
	localparam logic [7:0] SYNC_GAP_CYC = 8'h10;
	localparam logic [7:0] SYNC_LOW_CYC = 8'h80;
	localparam logic [4:0] CMD_BITS = 5'h08;

	// ********************************
	// Status and control byte
	// ********************************
	localparam int STAT_ENABLE_BIT = 7;
	localparam int STAT_HALTED_BIT = 6;
	localparam int STAT_CLKSEL_BIT = 2;
	localparam logic CTRL_ENABLE_RST = 1'b0;
	localparam logic CTRL_CLKSEL_RST = 1'b0;

	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] OP_BACKGROUND = 8'h90;
	localparam logic [7:0] OP_READ_STATUS = 8'hE4;
	localparam logic [7:0] OP_WRITE_CONTROL = 8'hC4;
	localparam logic [7:0] OP_READ_BYTE = 8'hE0;
	localparam logic [7:0] OP_READ_BYTE_WS = 8'hE1;
	localparam logic [7:0] OP_WRITE_BYTE = 8'hC0;
	localparam logic [7:0] OP_WRITE_BYTE_WS = 8'hC1;
	localparam logic [7:0] OP_GO = 8'h08;
	localparam logic [7:0] OP_STEP = 8'h10;
	localparam logic [4:0] OP_READ_REG_HI = 5'h0D;
	localparam logic [4:0] OP_WRITE_REG_HI = 5'h09;

	typedef enum logic [3:0] {
		ST_WAIT = 4'h0,
		ST_RX = 4'h1,
		ST_TX = 4'h2,
		ST_EXEC = 4'h3,
		ST_SYNC_HIGH = 4'h4,
		ST_SYNC_DLY = 4'h5,
		ST_SYNC_LOW = 4'h6,
		ST_SYNC_PULSE = 4'h7
	} bdl_state_t;

	typedef enum logic [3:0] {
		ACT_NONE = 4'h0,
		ACT_STAT = 4'h1,
		ACT_CTRL = 4'h2,
		ACT_MEM_RD = 4'h3,
		ACT_MEM_WR = 4'h4,
		ACT_REG_RD = 4'h5,
		ACT_REG_WR = 4'h6,
		ACT_GO = 4'h7,
		ACT_STEP = 4'h8,
		ACT_BGND = 4'h9
	} bdl_act_t;

	typedef struct packed {
		bdl_act_t act;
		logic [4:0] rx_len;
		logic [4:0] tx_len;
		logic halted_only;
		logic ws;
		logic [2:0] reg_sel;
	} bdl_dec_t;

endpackage

// ==== rtl/bdl_pin_sync.sv ====
// ********************************
// Three-stage input synchroniser
// ********************************
module bdl_pin_sync (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic async_in, // Asynchronous input
	output logic level, // Filtered level
	output logic fall, // One-cycle pulse on a falling change
	output logic rise // One-cycle pulse on a rising change
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	logic agree;

	// Level moves only when stages two and three agree
	always_comb begin
		agree = (s2 == s3);
		next_level = agree ? s3 : level;
		fall = level & ~next_level;
		rise = ~level & next_level;
	end

	// Stages run free; in reset the level follows the wire so the strap can be read
	// Low only once both stages agree low, so no false edge follows release
	always_ff @(posedge clk_sys) begin
		s1 <= async_in;
		s2 <= s1;
		s3 <= s2;
		if (!rst_n) begin
			level <= s2 | s3;
		end else begin
			level <= next_level;
		end
	end
endmodule

// ==== rtl/bdl_link.sv ====
// ********************************
// Single-wire debug link, target side
// ********************************
module bdl_link
	import bdl_pkg::*;
(
	input wire logic clk_sys, // 250 MHz system clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic debug_wire_pin_in, // Wire level seen at the pad
	output logic debug_wire_pin_out, // Level driven when enabled
	output logic debug_wire_pin_oe_n, // Low while driving the wire
	input wire logic alt_clk_in, // Alternate debug clock source
	output logic debug_clock_select, // 1: alternate debug clock
	output logic start_halted, // Strap: start in halted debug mode
	input wire logic cpu_halted, // Processor stopped in halted mode
	output logic cpu_halt_req, // Pulse: enter halted mode
	output logic cpu_go, // Pulse: resume user code
	output logic cpu_step, // Pulse: run one instruction
	output logic reg_req, // Register access request, held to ack
	output logic reg_we, // Register access is a write
	output logic [2:0] reg_sel, // Register select, low code bits
	output logic [15:0] reg_wdata, // Register write data
	input wire logic [15:0] reg_rdata, // Register read data
	input wire logic reg_ack, // Pulse: register access done
	output logic mem_req, // Memory access request, held to ack
	output logic mem_we, // Memory access is a write
	output logic [15:0] mem_addr, // Memory address
	output logic [7:0] mem_wdata, // Memory write data
	input wire logic [7:0] mem_rdata, // Memory read data
	input wire logic mem_ack // Pulse: memory access done
);
	// ********************************
	// Command decode
	// ********************************
	function automatic bdl_dec_t decode(input logic [7:0] op);
		bdl_dec_t d;
		d = '{ACT_NONE, 5'h00, 5'h00, 1'b0, 1'b0, op[2:0]};
		if (op[7:3] == OP_READ_REG_HI) begin
			d.act = ACT_REG_RD;
			d.halted_only = 1'b1;
			d.tx_len = (op[1:0] == 2'h0 || op[1:0] == 2'h1) ? 5'h08 : 5'h10;
		end else if (op[7:3] == OP_WRITE_REG_HI) begin
			d.act = ACT_REG_WR;
			d.halted_only = 1'b1;
			d.rx_len = (op[1:0] == 2'h0 || op[1:0] == 2'h1) ? 5'h08 : 5'h10;
		end else begin
			unique case (op)
				OP_BACKGROUND: d.act = ACT_BGND;
				OP_READ_STATUS: d = '{ACT_STAT, 5'h00, 5'h08, 1'b0, 1'b1, 3'h0};
				OP_WRITE_CONTROL: d = '{ACT_CTRL, 5'h08, 5'h00, 1'b0, 1'b0, 3'h0};
				OP_READ_BYTE: d = '{ACT_MEM_RD, 5'h10, 5'h08, 1'b0, 1'b0, 3'h0};
				OP_READ_BYTE_WS: d = '{ACT_MEM_RD, 5'h10, 5'h10, 1'b0, 1'b1, 3'h0};
				OP_WRITE_BYTE: d = '{ACT_MEM_WR, 5'h18, 5'h00, 1'b0, 1'b0, 3'h0};
				OP_WRITE_BYTE_WS: d = '{ACT_MEM_WR, 5'h18, 5'h08, 1'b0, 1'b1, 3'h0};
				OP_GO: d = '{ACT_GO, 5'h00, 5'h00, 1'b1, 1'b0, 3'h0};
				OP_STEP: d = '{ACT_STEP, 5'h00, 5'h00, 1'b1, 1'b0, 3'h0};
				default: d.act = ACT_NONE;
			endcase
		end
		return d;
	endfunction

	// ********************************
	// Input synchronisers
	// ********************************
	logic pin_level;
	logic pin_fall;
	logic alt_rise;

	bdl_pin_sync u_pin (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(debug_wire_pin_in),
		.level(pin_level),
		.fall(pin_fall),
		.rise()
	);

	bdl_pin_sync u_alt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(alt_clk_in),
		.level(),
		.fall(),
		.rise(alt_rise)
	);

	// ********************************
	// State
	// ********************************
	bdl_state_t state, next_state;
	bdl_dec_t dec, next_dec;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [7:0] gen_cnt, next_gen_cnt;
	logic [9:0] idle_cnt, next_idle_cnt;
	logic [6:0] low_cnt, next_low_cnt;
	logic have_cmd, next_have_cmd;
	logic [4:0] bits_left, next_bits_left;
	logic [4:0] tx_left, next_tx_left;
	logic [23:0] rx_sr, next_rx_sr;
	logic [15:0] tx_sr, next_tx_sr;
	logic halt_enable, next_halt_enable;
	logic next_clksel;
	logic drive_en, next_drive_en;
	logic next_drive_val;
	logic next_halt_req, next_go, next_step;
	logic next_mem_req, next_mem_we, next_reg_req, next_reg_we;
	logic [15:0] next_mem_addr, next_reg_wdata;
	logic [7:0] next_mem_wdata;
	logic [2:0] next_reg_sel;
	logic next_start_halted;
	logic tick, fall_ok, load, abort;
	logic [7:0] status, d8;
	logic [15:0] d16;
	bdl_dec_t cmd;

	// ********************************
	// Next-state logic
	// ********************************
	// Debug clock is a tick on the system clock; alternate source is edge-detected
	always_comb begin
		tick = debug_clock_select ? alt_rise : 1'b1;
		fall_ok = pin_fall & ~drive_en;
		status = 8'h00;
		status[STAT_ENABLE_BIT] = halt_enable;
		status[STAT_HALTED_BIT] = cpu_halted;
		status[STAT_CLKSEL_BIT] = debug_clock_select;
		next_state = state;
		next_dec = dec;
		next_bit_cnt = bit_cnt;
		next_gen_cnt = gen_cnt;
		next_have_cmd = have_cmd;
		next_bits_left = bits_left;
		next_tx_left = tx_left;
		next_rx_sr = rx_sr;
		next_tx_sr = tx_sr;
		next_halt_enable = halt_enable;
		next_clksel = debug_clock_select;
		next_drive_en = drive_en;
		next_drive_val = debug_wire_pin_out;
		next_halt_req = 1'b0;
		next_go = 1'b0;
		next_step = 1'b0;
		next_mem_req = mem_req;
		next_mem_we = mem_we;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_reg_req = reg_req;
		next_reg_we = reg_we;
		next_reg_sel = reg_sel;
		next_reg_wdata = reg_wdata;
		load = 1'b0;
		d8 = 8'h00;
		d16 = 16'h0000;
		cmd = decode({rx_sr[6:0], pin_level});
		// Strap follows the wire while reset is held; pullup means normal run
		next_start_halted = rst_n ? start_halted : ~pin_level;
		// Gap since the last host edge, saturating
		if (fall_ok) begin
			next_idle_cnt = 10'h000;
		end else if (tick && idle_cnt != TIMEOUT_CYC) begin
			next_idle_cnt = idle_cnt + 10'h001;
		end else begin
			next_idle_cnt = idle_cnt;
		end
		// Host low time; own drive does not count
		if (pin_level || drive_en) begin
			next_low_cnt = 7'h00;
		end else if (tick && low_cnt != SYNC_DETECT_CYC) begin
			next_low_cnt = low_cnt + 7'h01;
		end else begin
			next_low_cnt = low_cnt;
		end
		unique case (state)
			ST_WAIT: begin
				// Any host falling edge opens a bit; no reset or wake-up sequence needed
				if (fall_ok) begin
					next_bit_cnt = 5'h00;
					if (tx_left != 5'h00) begin
						next_state = ST_TX;
						next_drive_en = ~tx_sr[15];
						next_drive_val = 1'b0;
					end else begin
						next_state = ST_RX;
					end
				end
			end
			ST_RX: begin
				if (tick && bit_cnt == SAMPLE_CYC) begin
					next_rx_sr = {rx_sr[22:0], pin_level};
					next_bits_left = bits_left - 5'h01;
					next_state = ST_WAIT;
					if (!have_cmd && bits_left == 5'h01) begin
						// Unknown code, or halted-only code while running: drop it
						if (cmd.act == ACT_NONE || (cmd.halted_only && !cpu_halted)) begin
							next_bits_left = CMD_BITS;
						end else begin
							next_dec = cmd;
							next_have_cmd = 1'b1;
							next_bits_left = cmd.rx_len;
							if (cmd.rx_len == 5'h00) begin
								next_state = ST_EXEC;
							end
						end
					end else if (have_cmd && bits_left == 5'h01) begin
						next_state = ST_EXEC;
					end
				end else if (tick) begin
					next_bit_cnt = bit_cnt + 5'h01;
				end
			end
			ST_TX: begin
				if (tick) begin
					next_bit_cnt = bit_cnt + 5'h01;
					if (tx_sr[15] ? (next_bit_cnt == SPEEDUP_CYC) : (next_bit_cnt == TX0_LOW_CYC)) begin
						next_drive_en = 1'b1;
						next_drive_val = 1'b1;
					end else if (next_bit_cnt == (tx_sr[15] ? SPEEDUP_END : TX0_END)) begin
						next_drive_en = 1'b0;
						next_tx_sr = {tx_sr[14:0], 1'b0};
						next_tx_left = tx_left - 5'h01;
						next_state = ST_WAIT;
						if (tx_left == 5'h01) begin
							next_have_cmd = 1'b0;
							next_bits_left = CMD_BITS;
						end
					end
				end
			end
			ST_EXEC: begin
				unique case (dec.act)
					ACT_STAT: begin
						load = 1'b1;
					end
					ACT_CTRL: begin
						next_halt_enable = rx_sr[STAT_ENABLE_BIT];
						next_clksel = rx_sr[STAT_CLKSEL_BIT];
						load = 1'b1;
					end
					ACT_BGND: begin
						next_halt_req = halt_enable;
						load = 1'b1;
					end
					ACT_GO: begin
						next_go = 1'b1;
						load = 1'b1;
					end
					ACT_STEP: begin
						next_step = 1'b1;
						load = 1'b1;
					end
					ACT_MEM_RD, ACT_MEM_WR: begin
						// Memory touched only after every bit arrived, so aborts stay clean
						if (!mem_req) begin
							next_mem_req = 1'b1;
							next_mem_we = (dec.act == ACT_MEM_WR);
							next_mem_addr = (dec.act == ACT_MEM_WR) ? rx_sr[23:8] : rx_sr[15:0];
							next_mem_wdata = rx_sr[7:0];
						end else if (mem_ack) begin
							next_mem_req = 1'b0;
							d8 = mem_rdata;
							load = 1'b1;
						end
					end
					ACT_REG_RD, ACT_REG_WR: begin
						if (!reg_req) begin
							next_reg_req = 1'b1;
							next_reg_we = (dec.act == ACT_REG_WR);
							next_reg_sel = dec.reg_sel;
							next_reg_wdata = (dec.rx_len == 5'h08) ? {8'h00, rx_sr[7:0]} : rx_sr[15:0];
						end else if (reg_ack) begin
							next_reg_req = 1'b0;
							d8 = reg_rdata[7:0];
							d16 = reg_rdata;
							load = 1'b1;
						end
					end
					default: begin
						load = 1'b1;
					end
				endcase
				if (load) begin
					if (dec.ws) begin
						next_tx_sr = {status, d8};
					end else if (dec.tx_len == BIT_CYC) begin
						next_tx_sr = d16;
					end else begin
						next_tx_sr = {d8, 8'h00};
					end
					next_tx_left = dec.tx_len;
					next_state = ST_WAIT;
					if (dec.tx_len == 5'h00) begin
						next_have_cmd = 1'b0;
						next_bits_left = CMD_BITS;
					end
				end
			end
			ST_SYNC_HIGH: begin
				if (pin_level) begin
					next_gen_cnt = 8'h00;
					next_state = ST_SYNC_DLY;
				end
			end
			ST_SYNC_DLY: begin
				if (tick) begin
					next_gen_cnt = gen_cnt + 8'h01;
					if (next_gen_cnt == SYNC_GAP_CYC) begin
						next_gen_cnt = 8'h00;
						next_drive_en = 1'b1;
						next_drive_val = 1'b0;
						next_state = ST_SYNC_LOW;
					end
				end
			end
			ST_SYNC_LOW: begin
				if (tick) begin
					next_gen_cnt = gen_cnt + 8'h01;
					if (next_gen_cnt == SYNC_LOW_CYC) begin
						next_drive_val = 1'b1;
						next_state = ST_SYNC_PULSE;
					end
				end
			end
			ST_SYNC_PULSE: begin
				if (tick) begin
					next_drive_en = 1'b0;
					next_state = ST_WAIT;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
		// Sync request and silence both abandon a command still on the wire
		abort = 1'b0;
		if (state == ST_WAIT || state == ST_RX || state == ST_TX) begin
			if (low_cnt == SYNC_DETECT_CYC) begin
				abort = 1'b1;
				next_state = ST_SYNC_HIGH;
			end else if (idle_cnt == TIMEOUT_CYC && (have_cmd || bits_left != CMD_BITS)) begin
				abort = 1'b1;
				next_state = ST_WAIT;
			end
		end
		if (abort) begin
			next_have_cmd = 1'b0;
			next_bits_left = CMD_BITS;
			next_tx_left = 5'h00;
			next_drive_en = 1'b0;
		end
	end

	// ********************************
	// Registers
	// ********************************
	// No mapped registers; status and control live only behind the wire
	always_ff @(posedge clk_sys) begin
		start_halted <= next_start_halted;
		if (!rst_n) begin
			state <= ST_WAIT;
			dec <= '{ACT_NONE, 5'h00, 5'h00, 1'b0, 1'b0, 3'h0};
			bit_cnt <= 5'h00;
			gen_cnt <= 8'h00;
			idle_cnt <= 10'h000;
			low_cnt <= 7'h00;
			have_cmd <= 1'b0;
			bits_left <= CMD_BITS;
			tx_left <= 5'h00;
			rx_sr <= 24'h000000;
			tx_sr <= 16'h0000;
			halt_enable <= CTRL_ENABLE_RST;
			debug_clock_select <= CTRL_CLKSEL_RST;
			drive_en <= 1'b0;
			debug_wire_pin_out <= 1'b1;
			cpu_halt_req <= 1'b0;
			cpu_go <= 1'b0;
			cpu_step <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			reg_req <= 1'b0;
			reg_we <= 1'b0;
			reg_sel <= 3'h0;
			reg_wdata <= 16'h0000;
		end else begin
			state <= next_state;
			dec <= next_dec;
			bit_cnt <= next_bit_cnt;
			gen_cnt <= next_gen_cnt;
			idle_cnt <= next_idle_cnt;
			low_cnt <= next_low_cnt;
			have_cmd <= next_have_cmd;
			bits_left <= next_bits_left;
			tx_left <= next_tx_left;
			rx_sr <= next_rx_sr;
			tx_sr <= next_tx_sr;
			halt_enable <= next_halt_enable;
			debug_clock_select <= next_clksel;
			drive_en <= next_drive_en;
			debug_wire_pin_out <= next_drive_val;
			cpu_halt_req <= next_halt_req;
			cpu_go <= next_go;
			cpu_step <= next_step;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			reg_req <= next_reg_req;
			reg_we <= next_reg_we;
			reg_sel <= next_reg_sel;
			reg_wdata <= next_reg_wdata;
		end
	end

	assign debug_wire_pin_oe_n = ~drive_en;
endmodule

// ==== verif/bdl_link_asserts.sv ====
module bdl_link_asserts (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic debug_wire_pin_in, // Wire level
	input wire logic debug_wire_pin_out, // Driven level
	input wire logic debug_wire_pin_oe_n, // Low while driving
	input wire logic debug_clock_select, // Alternate clock
	input wire logic cpu_halted, // Processor stopped
	input wire logic cpu_go, // Resume pulse
	input wire logic cpu_step, // Step pulse
	input wire logic mem_req, // Memory request
	input wire logic mem_ack, // Memory done
	input wire logic [15:0] mem_addr, // Memory address
	input wire logic reg_req, // Register request
	input wire logic reg_ack // Register done
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********************************
	// Wire and handshake checks
	// ********************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] low_run, next_low_run; // Target low-drive length
	logic [9:0] quiet, next_quiet; // Cycles the wire stayed high
	// Run counters; quiet saturates so it never wraps back to zero
	always_comb begin
		next_low_run = (!debug_wire_pin_oe_n && !debug_wire_pin_out) ? low_run + 8'h01 : 8'h00;
		next_quiet = !debug_wire_pin_in ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
	end
	// Register the counters
	always_ff @(posedge clk_sys) begin
		low_run <= rst_n ? next_low_run : 8'h00;
		quiet <= rst_n ? next_quiet : 10'h000;
	end
	AST_SPEEDUP_ONE: assert property (
		!debug_clock_select && !debug_wire_pin_oe_n && debug_wire_pin_out |=> debug_wire_pin_oe_n)
		else $error("high drive longer than one tick");
	AST_LOW_RUN: assert property (
		!debug_clock_select && !debug_wire_pin_oe_n && debug_wire_pin_out && low_run != 8'h00
		|-> low_run inside {8'h0C, 8'h0D, 8'h80})
		else $error("low drive of wrong length");
	AST_HIGH_FREE: assert property (
		!debug_wire_pin_oe_n && debug_wire_pin_out |-> debug_wire_pin_in)
		else $error("high drive against a low wire");
	AST_PULSE_ONE: assert property (cpu_go || cpu_step |=> !cpu_go && !cpu_step)
		else $error("run pulse longer than a cycle");
	AST_HALTED_ONLY: assert property (cpu_go || cpu_step |-> cpu_halted)
		else $error("run pulse while not halted");
	AST_MEM_HOLD: assert property (
		mem_req && !mem_ack && !$past(mem_ack) |=> mem_req && $stable(mem_addr))
		else $error("memory request not held");
	AST_MEM_DROP: assert property (mem_ack |-> ##[1:2] !mem_req)
		else $error("memory request kept after ack");
	AST_REG_HOLD: assert property (reg_req && !reg_ack && !$past(reg_ack) |=> reg_req)
		else $error("register request not held");
	AST_QUIET: assert property (
		!debug_clock_select && quiet > 10'h240 |-> debug_wire_pin_oe_n && !mem_req && !reg_req)
		else $error("activity long after last host edge");
	cover property (low_run == 8'h80);
	cover property (cpu_step);
	cover property (mem_req && mem_ack);
endmodule

bind bdl_link bdl_link_asserts u_bdl_link_asserts (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.debug_wire_pin_in(debug_wire_pin_in),
	.debug_wire_pin_out(debug_wire_pin_out),
	.debug_wire_pin_oe_n(debug_wire_pin_oe_n),
	.debug_clock_select(debug_clock_select),
	.cpu_halted(cpu_halted),
	.cpu_go(cpu_go),
	.cpu_step(cpu_step),
	.mem_req(mem_req),
	.mem_ack(mem_ack),
	.mem_addr(mem_addr),
	.reg_req(reg_req),
	.reg_ack(reg_ack)
);

// ==== verif/bdl_pod_model.sv ====
module bdl_pod_model (
	input wire logic clk_sys, // Clock
	input wire logic wire_in, // Resolved wire level
	output logic pod_low, // Pod pulls the wire low
	output logic pod_high // Pod drives the wire high
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********************************
	// Host pod
	// ********************************
	int tick = 1; // Clock cycles per debug tick
	// Released at start; pullup holds the wire high
	initial begin
		pod_low = 1'b0;
		pod_high = 1'b0;
	end
	// Whole ticks, landing just after an edge
	task automatic wt(input int n);
		repeat (n * tick) @(posedge clk_sys);
		#1;
	endtask
	task automatic hold(input logic lo);
		pod_low = lo;
	endtask
	// Short low is a one, long low a zero; high speedup after
	task automatic put_bit(input logic b);
		pod_low = 1'b1;
		wt(b ? 3 : 16);
		pod_low = 1'b0;
		pod_high = 1'b1;
		wt(1);
		pod_high = 1'b0;
		wt(b ? 20 : 7);
	endtask
	// Brief low then release; wire read ten ticks in
	task automatic get_bit(output logic b);
		pod_low = 1'b1;
		wt(3);
		pod_low = 1'b0;
		wt(7);
		b = wire_in;
		wt(14);
	endtask
	// Fields go most significant bit first
	task automatic put(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			put_bit(v[i]);
		end
	endtask
	task automatic get(output logic [7:0] v);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			get_bit(b);
			v[i] = b;
		end
	endtask
	// Long low asks for sync; the answer is timed in ticks
	task automatic sync(output int gap, output int low);
		pod_low = 1'b1;
		wt(140);
		pod_low = 1'b0;
		pod_high = 1'b1;
		wt(1);
		pod_high = 1'b0;
		gap = 0;
		low = 0;
		while (wire_in && gap < 300) begin
			wt(1);
			gap++;
		end
		while (!wire_in && low < 300) begin
			wt(1);
			low++;
		end
	endtask
endmodule

// ==== verif/tb.sv ====
module tb import bdl_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	// ********************************
	// Bench
	// ********************************
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic alt_clk_in = 1'b0;
	logic cpu_halted = 1'b0;
	logic mem_ack = 1'b0;
	logic reg_ack = 1'b0;
	logic mem_seen = 1'b0;
	logic reg_seen = 1'b0;
	logic last_we = 1'b0;
	logic [7:0] mem_byte = 8'h00;
	logic [15:0] reg_val = 16'h0000;
	logic [15:0] last_addr = 16'h0000;
	logic [2:0] last_sel = 3'h0;
	logic pod_low, pod_high, wire_in, out, oe_n, select, strap;
	logic go, step, halt_req, mem_req, mem_we, reg_req, reg_we;
	logic [2:0] reg_sel;
	logic [15:0] mem_addr, reg_wdata;
	logic [7:0] mem_wdata;
	int mismatches = 0;
	int n_checks = 0;
	int n_go = 0, n_step = 0, n_halt = 0, n_mem = 0, clash = 0, cycles = 0;
	// Clocks; the alternate one drifts against clk_sys
	always #2 clk_sys = ~clk_sys;
	always #9.7 alt_clk_in = ~alt_clk_in;
	// Any low drive wins, pullup otherwise
	assign wire_in = !(pod_low || (!oe_n && !out));
	bdl_link u_bdl_link (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.debug_wire_pin_in(wire_in),
		.debug_wire_pin_out(out),
		.debug_wire_pin_oe_n(oe_n),
		.alt_clk_in(alt_clk_in),
		.debug_clock_select(select),
		.start_halted(strap),
		.cpu_halted(cpu_halted),
		.cpu_halt_req(halt_req),
		.cpu_go(go),
		.cpu_step(step),
		.reg_req(reg_req),
		.reg_we(reg_we),
		.reg_sel(reg_sel),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_val),
		.reg_ack(reg_ack),
		.mem_req(mem_req),
		.mem_we(mem_we),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_byte),
		.mem_ack(mem_ack)
	);
	bdl_pod_model u_bdl_pod_model (
		.clk_sys(clk_sys),
		.wire_in(wire_in),
		.pod_low(pod_low),
		.pod_high(pod_high)
	);
	// Prompt responders, pulse counters and the hang limit
	always @(posedge clk_sys) begin
		mem_seen <= mem_req;
		reg_seen <= reg_req;
		mem_ack <= mem_req && !mem_seen;
		reg_ack <= reg_req && !reg_seen;
		if (mem_req && !mem_seen) begin
			n_mem++;
			last_addr <= mem_addr;
			if (mem_we)
				mem_byte <= mem_wdata;
		end
		if (reg_req && !reg_seen) begin
			last_sel <= reg_sel;
			last_we <= reg_we;
			if (reg_we)
				reg_val <= reg_wdata;
		end
		n_go += int'(go);
		n_step += int'(step);
		n_halt += int'(halt_req);
		clash += int'(pod_high && !oe_n);
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic tx8(input logic [7:0] v);
		u_bdl_pod_model.put({8'h00, v}, 8);
	endtask
	task automatic tx16(input logic [15:0] v);
		u_bdl_pod_model.put(v, 16);
	endtask
	task automatic rx8(output logic [7:0] v);
		u_bdl_pod_model.get(v);
	endtask
	// Delay field of a command
	task automatic dly();
		u_bdl_pod_model.wt(16);
	endtask
	task automatic stat(input logic [7:0] exp);
		logic [7:0] v;
		tx8(OP_READ_STATUS);
		rx8(v);
		chk("status", {8'h00, exp}, {8'h00, v});
	endtask
	// Enable gates the halt request; select slows the bits
	task automatic t_ctrl();
		int n;
		for (int i = 0; i < 2; i++) begin
			n = n_halt;
			tx8(OP_WRITE_CONTROL);
			tx8(i[0] ? 8'h80 : 8'h00);
			tx8(OP_BACKGROUND);
			dly();
			chk("halt request", 16'(n + i), 16'(n_halt));
		end
		tx8(OP_WRITE_CONTROL);
		tx8(8'h84);
		chk("clock select", 16'h0001, {15'h0000, select});
		u_bdl_pod_model.tick = 5;
		stat(8'hC4);
		tx8(OP_WRITE_CONTROL);
		tx8(8'h80);
		u_bdl_pod_model.tick = 1;
		stat(8'hC0);
	endtask
	// Byte write, then read back with status first
	task automatic t_mem();
		logic [7:0] v;
		tx8(OP_WRITE_BYTE);
		tx16(16'h12C3);
		tx8(8'hA5);
		dly();
		chk("write addr", 16'h12C3, last_addr);
		chk("write data", 16'h00A5, {8'h00, mem_byte});
		tx8(OP_READ_BYTE_WS);
		tx16(16'h12C3);
		dly();
		rx8(v);
		chk("ws status", 16'h00C0, {8'h00, v});
		rx8(v);
		chk("read data", 16'h00A5, {8'h00, v});
		tx8(OP_WRITE_BYTE_WS);
		tx16(16'h0040);
		tx8(8'h3C);
		dly();
		rx8(v);
		chk("wsw status", 16'h00C0, {8'h00, v});
		tx8(OP_READ_BYTE);
		tx16(16'h0040);
		dly();
		rx8(v);
		chk("plain read", 16'h003C, {8'h00, v});
		chk("read addr", 16'h0040, last_addr);
	endtask
	// Halted commands refused while running, obeyed when halted
	task automatic t_regs();
		logic [7:0] v;
		int g;
		int s;
		g = n_go;
		s = n_step;
		cpu_halted = 1'b0;
		tx8(OP_GO);
		dly();
		chk("go refused", 16'(g), 16'(n_go));
		cpu_halted = 1'b1;
		tx8(OP_GO);
		dly();
		tx8(OP_STEP);
		dly();
		chk("go", 16'(g + 1), 16'(n_go));
		chk("step", 16'(s + 1), 16'(n_step));
		tx8({OP_WRITE_REG_HI, 3'h3});
		tx16(16'hBEEF);
		dly();
		chk("reg write", 16'hBEEF, reg_val);
		chk("reg select", 16'h000B, {12'h000, last_we, last_sel});
		tx8({OP_READ_REG_HI, 3'h0});
		dly();
		rx8(v);
		chk("reg read", 16'h00EF, {8'h00, v});
		tx8({OP_READ_REG_HI, 3'h3});
		dly();
		rx8(v);
		chk("reg read hi", 16'h00BE, {8'h00, v});
		rx8(v);
		chk("reg read lo", 16'h00EF, {8'h00, v});
		chk("reg read sel", 16'h0003, {12'h000, last_we, last_sel});
	endtask
	// Half an address then silence: nothing may be written
	task automatic t_timeout();
		int n;
		n = n_mem;
		tx8(OP_WRITE_BYTE);
		tx8(8'h12);
		u_bdl_pod_model.wt(600);
		stat(8'hC0);
		chk("aborted write", 16'(n), 16'(n_mem));
	endtask
	// Sync answer: short gap, then exactly 128 ticks low
	task automatic t_sync();
		int gap;
		int low;
		u_bdl_pod_model.sync(gap, low);
		chk("sync low", 16'h0080, 16'(low));
		chk("sync gap", 16'h0001, {15'h0000, gap >= 15 && gap <= 24});
		u_bdl_pod_model.wt(20);
	endtask
	// Wire level during reset picks the start mode
	task automatic t_strap();
		for (int i = 1; i >= 0; i--) begin
			u_bdl_pod_model.hold(i[0]);
			rst_n = 1'b0;
			cyc(6);
			rst_n = 1'b1;
			cyc(2);
			u_bdl_pod_model.hold(1'b0);
			chk("strap", {15'h0000, i[0]}, {15'h0000, strap});
		end
	endtask
	// Main sequence
	initial begin
		cyc(3);
		rst_n = 1'b1;
		stat(8'h00);
		cpu_halted = 1'b1;
		stat(8'h40);
		t_ctrl();
		t_mem();
		t_regs();
		t_timeout();
		t_sync();
		t_strap();
		stat(8'h40);
		chk("wire clash", 16'h0000, 16'(clash));
		tally_and_finish();
	end
endmodule
